// ### uart_baud_pkg.sv
// constants, register map and types for the baud, auto-baud and flag block
package uart_baud_pkg;
  localparam int ADDR_W = 8;
  localparam int DIV_W = 20;
  localparam int DIV_LOW_W = 16;
  localparam int DIV_HIGH_W = 4;
  localparam int AB_CNT_W = DIV_W + 7;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DIV_LOW = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DIV_HIGH = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_SC_IRQ = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_EV_IRQ = 8'h14;
  // control register fields
  localparam int CTRL_MODULE_EN = 15;
  localparam int CTRL_WAKE_EN = 12;
  localparam int CTRL_SRC_SEL_LO = 9;
  localparam int CTRL_FRAC_SEL = 7;
  localparam int CTRL_AUTOBAUD_EN = 6;
  localparam int CTRL_TX_RPT_LO = 4;
  localparam int CTRL_HS_PRESCALER = 3;
  // status register fields
  localparam int ST_OVF_IRQ_EN = 13;
  localparam int ST_OVF_FLAG = 5;
  localparam int ST_BREAK_FLAG = 2;
  // smart card interrupt register fields
  localparam int SC_RX_RPT_FLAG = 13;
  localparam int SC_TX_RPT_FLAG = 12;
  localparam int SC_BLOCK_FLAG = 10;
  localparam int SC_WAIT_FLAG = 9;
  localparam int SC_GUARD_FLAG = 8;
  localparam int SC_RX_RPT_EN = 5;
  localparam int SC_TX_RPT_EN = 4;
  localparam int SC_BLOCK_EN = 2;
  localparam int SC_WAIT_EN = 1;
  localparam int SC_GUARD_EN = 0;
  // event interrupt register fields
  localparam int EV_WAKE_FLAG = 7;
  localparam int EV_AB_DONE_FLAG = 6;
  localparam int EV_AB_DONE_EN = 2;
  // reset values and counts
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [DIV_W-1:0] DIV_RESET = 20'h00000;
  localparam logic [2:0] RX_RPT_RECEPTIONS = 3'h5;
  localparam logic [2:0] AB_FALL_EDGES = 3'h5;
  localparam logic [3:0] PRESCALE_LEGACY_LAST = 4'hF;
  localparam logic [3:0] PRESCALE_HIGH_LAST = 4'h3;
  localparam int AB_SHIFT_LEGACY = 7;
  localparam int AB_SHIFT_HIGH = 5;
  localparam int AB_SHIFT_FRAC = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic rxCharDone;
    logic rxParityErr;
    logic txCharDone;
    logic txLineErr;
    logic blockTimeZero;
    logic waitTimeZero;
    logic guardTimeZero;
  } sc_events_t;

  typedef enum logic [1:0] {
    AB_IDLE = 2'h0,
    AB_START = 2'h1,
    AB_MEAS = 2'h3,
    AB_OVF = 2'h2
  } ab_state_t;
endpackage

// ### uart_baud_autobaud_irq.sv
// baud generator, auto-baud measurement and interrupt flags behind an AXI4-Lite slave
// Notes on behaviour
// - fifth reception with parity error sets rx repeat
// - error after last allowed retransmit sets tx repeat
// - block time flag sets at zero only
// - waiting time flag sets at zero
// - guard time flag sets at zero
// - smart card irq needs flag and enable
// - rx falling edge sets sticky wake flag
// - final sync falling edge sets done flag
// - done flag interrupts only when enabled
// - two-bit field picks one of four sources
// - source and prescaler change only while disabled
// - legacy rate divides by 16 or 4 times
// - upper four divisor bits in high register
// - fractional rate divides by divisor, ignores prescaler
// - auto-baud times sync falling edges, loads divisor
// - completion clears auto-baud enable, sets done
// - rollover before fifth edge sets overflow flag
// - wake with auto-baud skips break, no break flag
module uart_baud_autobaud_irq (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rxLine,
  input wire logic [3:0] clkSrcTick,
  input wire uart_baud_pkg::sc_events_t scEvents,
  input wire logic breakDetect,
  output logic baudTick,
  output logic smartCardIrq,
  output logic eventIrq
);

  function automatic logic [15:0] mergeStrb(logic [15:0] old, logic [31:0] d, logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  function automatic logic isMapped(logic [7:0] a);
    return a == uart_baud_pkg::OFF_CTRL || a == uart_baud_pkg::OFF_DIV_LOW ||
           a == uart_baud_pkg::OFF_DIV_HIGH || a == uart_baud_pkg::OFF_STATUS ||
           a == uart_baud_pkg::OFF_SC_IRQ || a == uart_baud_pkg::OFF_EV_IRQ;
  endfunction

  // bus handshake state
  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [7:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic bValid_q, bValid_d, rValid_q, rValid_d;
  logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
  logic [31:0] rData_q, rData_d;
  logic wrFire;
  logic [15:0] regView [6];

  localparam int DIV_W_LOC = uart_baud_pkg::DIV_W;

  // core state
  logic moduleEn_q, moduleEn_d, wakeEn_q, wakeEn_d, fracSel_q, fracSel_d;
  logic hsPre_q, hsPre_d, abEn_q, abEn_d;
  logic [1:0] srcSel_q, srcSel_d, txRptCount_q, txRptCount_d;
  logic [DIV_W_LOC-1:0] divisor_q, divisor_d;
  logic ovfIrqEn_q, ovfIrqEn_d, ovfFlag_q, ovfFlag_d, breakFlag_q, breakFlag_d;
  logic [4:0] scFlag_q, scFlag_d, scEn_q, scEn_d;
  logic wakeFlag_q, wakeFlag_d, abDoneFlag_q, abDoneFlag_d, abDoneEn_q, abDoneEn_d;
  logic [DIV_W_LOC-1:0] divCnt_q, divCnt_d;
  logic [3:0] preCnt_q, preCnt_d;
  logic baudTick_q, baudTick_d;
  uart_baud_pkg::ab_state_t abState_q, abState_d;
  logic [uart_baud_pkg::AB_CNT_W-1:0] abCnt_q, abCnt_d;
  logic [2:0] abEdges_q, abEdges_d, rxRptCnt_q, rxRptCnt_d, txErrCnt_q, txErrCnt_d;
  logic rxPrev_q, rxPrev_d;

  assign awready = !awHeld_q;
  assign wready = !wHeld_q;
  assign arready = !rValid_q;
  assign bvalid = bValid_q;
  assign bresp = bResp_q;
  assign rvalid = rValid_q;
  assign rresp = rResp_q;
  assign rdata = rData_q;
  assign baudTick = baudTick_q;
  // both halves of a write must be in before it lands; one response outstanding at most
  assign wrFire = awHeld_q && wHeld_q && !bValid_q;

  always_comb begin
    regView[0] = '0;
    regView[0][uart_baud_pkg::CTRL_MODULE_EN] = moduleEn_q;
    regView[0][uart_baud_pkg::CTRL_WAKE_EN] = wakeEn_q;
    regView[0][uart_baud_pkg::CTRL_SRC_SEL_LO +: 2] = srcSel_q;
    regView[0][uart_baud_pkg::CTRL_FRAC_SEL] = fracSel_q;
    regView[0][uart_baud_pkg::CTRL_AUTOBAUD_EN] = abEn_q;
    regView[0][uart_baud_pkg::CTRL_TX_RPT_LO +: 2] = txRptCount_q;
    regView[0][uart_baud_pkg::CTRL_HS_PRESCALER] = hsPre_q;
    regView[1] = divisor_q[15:0];
    regView[2] = {12'h000, divisor_q[DIV_W_LOC-1:16]};
    regView[3] = '0;
    regView[3][uart_baud_pkg::ST_OVF_IRQ_EN] = ovfIrqEn_q;
    regView[3][uart_baud_pkg::ST_OVF_FLAG] = ovfFlag_q;
    regView[3][uart_baud_pkg::ST_BREAK_FLAG] = breakFlag_q;
    regView[4] = {2'h0, scFlag_q[4:3], 1'h0, scFlag_q[2:0], 2'h0, scEn_q[4:3], 1'h0, scEn_q[2:0]};
    regView[5] = '0;
    regView[5][uart_baud_pkg::EV_WAKE_FLAG] = wakeFlag_q;
    regView[5][uart_baud_pkg::EV_AB_DONE_FLAG] = abDoneFlag_q;
    regView[5][uart_baud_pkg::EV_AB_DONE_EN] = abDoneEn_q;
  end

  always_comb begin
    awHeld_d = awHeld_q;
    awAddr_d = awAddr_q;
    wHeld_d = wHeld_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bValid_d = bValid_q;
    bResp_d = bResp_q;
    rValid_d = rValid_q;
    rResp_d = rResp_q;
    rData_d = rData_q;
    if (awvalid && !awHeld_q) begin
      awHeld_d = 1'b1;
      awAddr_d = awaddr;
    end
    if (wvalid && !wHeld_q) begin
      wHeld_d = 1'b1;
      wData_d = wdata;
      wStrb_d = wstrb;
    end
    if (wrFire) begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bValid_d = 1'b1;
      bResp_d = isMapped(awAddr_q) ? uart_baud_pkg::RESP_OKAY : uart_baud_pkg::RESP_SLVERR;
    end else if (bValid_q && bready) begin
      bValid_d = 1'b0;
    end
    if (arvalid && !rValid_q) begin
      rValid_d = 1'b1;
      rResp_d = isMapped(araddr) ? uart_baud_pkg::RESP_OKAY : uart_baud_pkg::RESP_SLVERR;
      rData_d = isMapped(araddr) ? {16'h0000, regView[araddr[4:2]]} : 32'h00000000;
    end else if (rValid_q && rready) begin
      rValid_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wHeld_q <= 1'b0;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q <= 2'h0;
      rValid_q <= 1'b0;
      rResp_q <= 2'h0;
      rData_q <= 32'h00000000;
    end else begin
      awHeld_q <= awHeld_d;
      awAddr_q <= awAddr_d;
      wHeld_q <= wHeld_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bValid_q <= bValid_d;
      bResp_q <= bResp_d;
      rValid_q <= rValid_d;
      rResp_q <= rResp_d;
      rData_q <= rData_d;
    end
  end

  logic srcTick, rxFall, abFinish, abRoll;
  logic [15:0] wv;
  logic [4:0] scSet, scClr;
  logic [uart_baud_pkg::AB_CNT_W-1:0] abQuot;
  logic [DIV_W_LOC-1:0] divLimit;

  always_comb begin
    wv = '0;
    scSet = '0;
    scClr = '0;
    abQuot = '0;
    divLimit = '0;
    moduleEn_d = moduleEn_q;
    wakeEn_d = wakeEn_q;
    srcSel_d = srcSel_q;
    fracSel_d = fracSel_q;
    abEn_d = abEn_q;
    txRptCount_d = txRptCount_q;
    hsPre_d = hsPre_q;
    divisor_d = divisor_q;
    ovfIrqEn_d = ovfIrqEn_q;
    ovfFlag_d = ovfFlag_q;
    breakFlag_d = breakFlag_q;
    scFlag_d = scFlag_q;
    scEn_d = scEn_q;
    wakeFlag_d = wakeFlag_q;
    abDoneFlag_d = abDoneFlag_q;
    abDoneEn_d = abDoneEn_q;
    divCnt_d = divCnt_q;
    preCnt_d = preCnt_q;
    baudTick_d = 1'b0;
    abState_d = abState_q;
    abCnt_d = abCnt_q;
    abEdges_d = abEdges_q;
    rxRptCnt_d = rxRptCnt_q;
    txErrCnt_d = txErrCnt_q;
    rxPrev_d = rxLine;
    srcTick = clkSrcTick[srcSel_q];
    rxFall = rxPrev_q && !rxLine;
    abFinish = 1'b0;
    abRoll = 1'b0;

    // software writes; flags take a zero as a clear, a one is ignored
    if (wrFire) begin
      wv = mergeStrb(regView[awAddr_q[4:2]], wData_q, wStrb_q);
      unique case (awAddr_q)
        uart_baud_pkg::OFF_CTRL: begin
          moduleEn_d = wv[uart_baud_pkg::CTRL_MODULE_EN];
          wakeEn_d = wv[uart_baud_pkg::CTRL_WAKE_EN];
          abEn_d = wv[uart_baud_pkg::CTRL_AUTOBAUD_EN];
          txRptCount_d = wv[uart_baud_pkg::CTRL_TX_RPT_LO +: 2];
          // clocking fields are frozen while running to avoid a glitched bit clock
          if (!moduleEn_q) begin
            srcSel_d = wv[uart_baud_pkg::CTRL_SRC_SEL_LO +: 2];
            fracSel_d = wv[uart_baud_pkg::CTRL_FRAC_SEL];
            hsPre_d = wv[uart_baud_pkg::CTRL_HS_PRESCALER];
          end
        end
        uart_baud_pkg::OFF_DIV_LOW: divisor_d[15:0] = wv;
        uart_baud_pkg::OFF_DIV_HIGH: divisor_d[DIV_W_LOC-1:16] = wv[3:0];
        uart_baud_pkg::OFF_STATUS: begin
          ovfIrqEn_d = wv[uart_baud_pkg::ST_OVF_IRQ_EN];
          // overflow stays up while auto-baud is still enabled
          if (!abEn_q && !wv[uart_baud_pkg::ST_OVF_FLAG]) begin
            ovfFlag_d = 1'b0;
          end
          if (!wv[uart_baud_pkg::ST_BREAK_FLAG]) begin
            breakFlag_d = 1'b0;
          end
        end
        uart_baud_pkg::OFF_SC_IRQ: begin
          scEn_d = {wv[5:4], wv[2:0]};
          scClr = ~{wv[13:12], wv[10:8]};
        end
        uart_baud_pkg::OFF_EV_IRQ: begin
          abDoneEn_d = wv[uart_baud_pkg::EV_AB_DONE_EN];
          if (!wv[uart_baud_pkg::EV_WAKE_FLAG]) begin
            wakeFlag_d = 1'b0;
          end
          if (!wv[uart_baud_pkg::EV_AB_DONE_FLAG]) begin
            abDoneFlag_d = 1'b0;
          end
        end
        default: ;
      endcase
    end

    if (!moduleEn_q) begin
      // a disabled module holds its counters in reset
      divCnt_d = '0;
      preCnt_d = '0;
      abState_d = uart_baud_pkg::AB_IDLE;
      abCnt_d = '0;
      abEdges_d = '0;
      rxRptCnt_d = '0;
      txErrCnt_d = '0;
    end else begin
      // bit clock generation
      if (fracSel_q) begin
        divLimit = (divisor_q == '0) ? '0 : divisor_q - 1'b1;
        if (srcTick) begin
          if (divCnt_q >= divLimit) begin
            divCnt_d = '0;
            baudTick_d = 1'b1;
          end else begin
            divCnt_d = divCnt_q + 1'b1;
          end
        end
      end else if (srcTick) begin
        if (divCnt_q >= divisor_q) begin
          divCnt_d = '0;
          if (preCnt_q >= (hsPre_q ? uart_baud_pkg::PRESCALE_HIGH_LAST
                                   : uart_baud_pkg::PRESCALE_LEGACY_LAST)) begin
            preCnt_d = '0;
            baudTick_d = 1'b1;
          end else begin
            preCnt_d = preCnt_q + 1'b1;
          end
        end else begin
          divCnt_d = divCnt_q + 1'b1;
        end
      end

      // auto-baud measurement of the sync character
      unique case (abState_q)
        uart_baud_pkg::AB_IDLE: begin
          // a break still on the line is skipped before arming
          if (abEn_q && rxLine) begin
            abState_d = uart_baud_pkg::AB_START;
          end
        end
        uart_baud_pkg::AB_START: begin
          if (!abEn_q) begin
            abState_d = uart_baud_pkg::AB_IDLE;
          end else if (rxFall) begin
            abState_d = uart_baud_pkg::AB_MEAS;
            abCnt_d = '0;
            abEdges_d = 3'h1;
          end
        end
        uart_baud_pkg::AB_MEAS: begin
          abRoll = srcTick && (&abCnt_q);
          if (!abEn_q) begin
            abState_d = uart_baud_pkg::AB_IDLE;
          end else if (wakeEn_q && breakDetect) begin
            // the edge that started this run was a break, not the sync; re-arm
            abState_d = uart_baud_pkg::AB_START;
          end else if (rxFall && abEdges_q == uart_baud_pkg::AB_FALL_EDGES - 3'h1) begin
            abFinish = 1'b1;
            abState_d = uart_baud_pkg::AB_IDLE;
          end else if (abRoll) begin
            abState_d = uart_baud_pkg::AB_OVF;
          end else begin
            if (srcTick) begin
              abCnt_d = abCnt_q + 1'b1;
            end
            if (rxFall) begin
              abEdges_d = abEdges_q + 3'h1;
            end
          end
        end
        uart_baud_pkg::AB_OVF: begin
          if (!abEn_q) begin
            abState_d = uart_baud_pkg::AB_IDLE;
          end
        end
        default: abState_d = uart_baud_pkg::AB_IDLE;
      endcase

      if (abFinish) begin
        // four bit pairs span eight bit times between the first and fifth falling edges
        if (fracSel_q) begin
          abQuot = abCnt_q >> uart_baud_pkg::AB_SHIFT_FRAC;
          divisor_d = abQuot[DIV_W_LOC-1:0];
        end else begin
          abQuot = abCnt_q >> (hsPre_q ? uart_baud_pkg::AB_SHIFT_HIGH
                                       : uart_baud_pkg::AB_SHIFT_LEGACY);
          divisor_d = (abQuot == '0) ? '0 : abQuot[DIV_W_LOC-1:0] - 1'b1;
        end
        abEn_d = 1'b0;
      end

      // consecutive repeats of one character
      if (scEvents.rxCharDone) begin
        if (!scEvents.rxParityErr) begin
          rxRptCnt_d = '0;
        end else if (rxRptCnt_q == uart_baud_pkg::RX_RPT_RECEPTIONS - 3'h1) begin
          rxRptCnt_d = '0;
          scSet[4] = 1'b1;
        end else begin
          rxRptCnt_d = rxRptCnt_q + 3'h1;
        end
      end
      if (scEvents.txCharDone) begin
        if (!scEvents.txLineErr) begin
          txErrCnt_d = '0;
        end else if (txErrCnt_q == {1'b0, txRptCount_q} + 3'h1) begin
          // original send plus count+1 retransmits all failed
          txErrCnt_d = '0;
          scSet[3] = 1'b1;
        end else begin
          txErrCnt_d = txErrCnt_q + 3'h1;
        end
      end
      scSet[2] = scEvents.blockTimeZero;
      scSet[1] = scEvents.waitTimeZero;
      scSet[0] = scEvents.guardTimeZero;
    end

    // hardware sets come last so they win over a clear in the same cycle
    scFlag_d = (scFlag_q & ~scClr) | scSet;
    if (abFinish) begin
      abDoneFlag_d = 1'b1;
    end
    if (abRoll && moduleEn_q && abEn_q) begin
      ovfFlag_d = 1'b1;
    end
    if (wakeEn_q && rxFall) begin
      wakeFlag_d = 1'b1;
    end
    if (breakDetect && !(wakeEn_q && abEn_q)) begin
      breakFlag_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      moduleEn_q <= 1'b0;
      wakeEn_q <= 1'b0;
      srcSel_q <= 2'h0;
      fracSel_q <= 1'b0;
      abEn_q <= 1'b0;
      txRptCount_q <= 2'h0;
      hsPre_q <= 1'b0;
      divisor_q <= uart_baud_pkg::DIV_RESET;
      ovfIrqEn_q <= 1'b0;
      ovfFlag_q <= 1'b0;
      breakFlag_q <= 1'b0;
      scFlag_q <= 5'h00;
      scEn_q <= 5'h00;
      wakeFlag_q <= 1'b0;
      abDoneFlag_q <= 1'b0;
      abDoneEn_q <= 1'b0;
      divCnt_q <= uart_baud_pkg::DIV_RESET;
      preCnt_q <= 4'h0;
      baudTick_q <= 1'b0;
      abState_q <= uart_baud_pkg::AB_IDLE;
      abCnt_q <= '0;
      abEdges_q <= 3'h0;
      rxRptCnt_q <= 3'h0;
      txErrCnt_q <= 3'h0;
      rxPrev_q <= 1'b1;
    end else begin
      moduleEn_q <= moduleEn_d;
      wakeEn_q <= wakeEn_d;
      srcSel_q <= srcSel_d;
      fracSel_q <= fracSel_d;
      abEn_q <= abEn_d;
      txRptCount_q <= txRptCount_d;
      hsPre_q <= hsPre_d;
      divisor_q <= divisor_d;
      ovfIrqEn_q <= ovfIrqEn_d;
      ovfFlag_q <= ovfFlag_d;
      breakFlag_q <= breakFlag_d;
      scFlag_q <= scFlag_d;
      scEn_q <= scEn_d;
      wakeFlag_q <= wakeFlag_d;
      abDoneFlag_q <= abDoneFlag_d;
      abDoneEn_q <= abDoneEn_d;
      divCnt_q <= divCnt_d;
      preCnt_q <= preCnt_d;
      baudTick_q <= baudTick_d;
      abState_q <= abState_d;
      abCnt_q <= abCnt_d;
      abEdges_q <= abEdges_d;
      rxRptCnt_q <= rxRptCnt_d;
      txErrCnt_q <= txErrCnt_d;
      rxPrev_q <= rxPrev_d;
    end
  end

  assign smartCardIrq = |(scFlag_q & scEn_q);
  assign eventIrq = wakeFlag_q || (abDoneFlag_q && abDoneEn_q) || (ovfFlag_q && ovfIrqEn_q);

endmodule // uart_baud_autobaud_irq

// ### uart_baud_checker.sv
// port-level assertions for the baud, auto-baud and flag block
module uart_baud_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [3:0] clkSrcTick,
  input wire uart_baud_pkg::sc_events_t scEvents,
  input wire logic rxLine,
  input wire logic baudTick,
  input wire logic smartCardIrq,
  input wire logic eventIrq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // a write lands in the cycle awready rises again, so a low awready now or one cycle back is allowed
  property p_sc_rise;
    $rose(smartCardIrq) |-> $past(|scEvents) || !awready || !$past(awready);
  endproperty
  a_sc_rise: assert property (p_sc_rise) else $error("card irq rose without cause");
  property p_sc_hold;
    $fell(smartCardIrq) |-> !awready || !$past(awready);
  endproperty
  a_sc_hold: assert property (p_sc_hold) else $error("card irq fell without write");
  property p_ev_rise;
    $rose(eventIrq) |-> !awready || !$past(awready) || ($past(rxLine, 2) && !$past(rxLine));
  endproperty
  a_ev_rise: assert property (p_ev_rise) else $error("event irq rose without cause");
  property p_ev_hold;
    $fell(eventIrq) |-> !awready || !$past(awready);
  endproperty
  a_ev_hold: assert property (p_ev_hold) else $error("event irq fell without write");
  property p_tick_src;
    baudTick |-> $past(|clkSrcTick);
  endproperty
  a_tick_src: assert property (p_tick_src) else $error("tick without source");
  property p_aw_busy;
    awvalid && awready |=> !awready;
  endproperty
  a_aw_busy: assert property (p_aw_busy) else $error("second write address taken");
  property p_rd_answer;
    arvalid && arready |=> rvalid && rdata[31:16] == 16'h0000;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late or wide");
  property p_rd_hold;
    rvalid |=> ($past(rready) && !rvalid) || (!$past(rready) && rvalid && $stable(rdata));
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped early");
endmodule // uart_baud_checker

bind uart_baud_autobaud_irq uart_baud_checker chk (.clk(clk), .rst(rst), .awvalid(awvalid),
  .awready(awready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .clkSrcTick(clkSrcTick), .scEvents(scEvents), .rxLine(rxLine),
  .baudTick(baudTick), .smartCardIrq(smartCardIrq), .eventIrq(eventIrq));

// ### rx_line_model.sv
// remote transmitter that sends one sync character on the receive line
module rx_line_model (
  input wire logic clk,
  input wire logic go,
  input var int bitLen,
  input var int brkLen,
  output logic rxLine
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] frame;
  // start bit runs 4 cycles longer than a bit time so the measured span sits mid-way between fractional divisor steps
  initial begin
    rxLine = 1'b1;
    forever begin
      @(posedge go);
      // an optional break and one idle bit time go ahead of the sync character
      if (brkLen > 0) begin
        rxLine <= 1'b0;
        repeat (brkLen) @(posedge clk);
        rxLine <= 1'b1;
        repeat (bitLen) @(posedge clk);
      end
      frame = {1'b1, 8'h55, 1'b0};
      for (int i = 0; i < 10; i++) begin
        rxLine <= frame[i];
        repeat (bitLen + (i == 0 ? 4 : 0)) @(posedge clk);
      end
    end
  end
endmodule // rx_line_model

// ### tb.sv
// self-checking bench for the baud, auto-baud and flag block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(got, want) begin numChecks++; if ((got) !== (want)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, want); end end
  logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, go = 1'b0, breakDetect = 1'b0, rxLine;
  logic awready, wready, bvalid, arready, rvalid, baudTick, smartCardIrq, eventIrq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic [3:0] wstrb = 4'hF, clkSrcTick = 4'hF;
  logic [1:0] bresp, rresp;
  uart_baud_pkg::sc_events_t scEvents = 7'h00;
  int failures = 0, numChecks = 0, seed = 32'hAAA893BD, bitLen = 170;
  int cyc = 0, lastTick = 0, tickGap = 0, brkLen = 0;
  int exp[7] = '{7{0}};
  int rwM[7] = '{32'h96F8, 32'hFFFF, 32'hF, 32'h2000, 32'h37, 32'h4, 0};
  int flM[7] = '{0, 0, 0, 32'h24, 32'h3700, 32'hC0, 0};

  uart_baud_autobaud_irq dut (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rxLine(rxLine), .clkSrcTick(clkSrcTick), .scEvents(scEvents),
    .breakDetect(breakDetect), .baudTick(baudTick), .smartCardIrq(smartCardIrq),
    .eventIrq(eventIrq));
  rx_line_model far (.clk(clk), .go(go), .bitLen(bitLen), .brkLen(brkLen), .rxLine(rxLine));

  always #10 clk = ~clk;
  // the selected source always ticks, the others toggle at random
  always @(posedge clk) begin
    cyc <= cyc + 1;
    clkSrcTick <= 4'($random(seed)) | (4'h1 << exp[0][10:9]);
    if (baudTick) begin
      tickGap <= cyc - lastTick;
      lastTick <= cyc;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin @(posedge clk iff awready); awvalid <= 1'b0; end
      begin @(posedge clk iff wready); wvalid <= 1'b0; end
    join
    @(posedge clk iff bvalid);
    bready <= 1'b0;
    `CHK(bresp, a < 8'h18 ? uart_baud_pkg::RESP_OKAY : uart_baud_pkg::RESP_SLVERR)
    // idle cycle keeps divisor writes apart
    @(posedge clk);
  endtask
  task automatic w(input int a, input int d);
    if (a == 0 && exp[0][15]) d = (d & ~32'h688) | (exp[0] & 32'h688);
    exp[a] = (d & rwM[a]) | (exp[a] & flM[a] & d);
    wr(8'(a * 4), d);
  endtask
  task automatic rd(input int a, input int e);
    logic [31:0] got;
    logic [1:0] resp;
    araddr <= 8'(a * 4);
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge clk iff arready);
    arvalid <= 1'b0;
    @(posedge clk iff rvalid);
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge clk);
    `CHK(got, e)
    `CHK(resp, a < 6 ? uart_baud_pkg::RESP_OKAY : uart_baud_pkg::RESP_SLVERR)
  endtask
  task automatic pulse(input logic [6:0] e, input int n);
    repeat (n) begin
      scEvents <= e;
      @(posedge clk);
      scEvents <= 7'h00;
      @(posedge clk);
    end
  endtask
  task automatic brk;
    breakDetect <= 1'b1;
    @(posedge clk);
    breakDetect <= 1'b0;
  endtask
  task automatic sync;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    // the break pulse lands while the line is still held low
    if (brkLen > 0) begin
      repeat (11 * bitLen) @(posedge clk);
      brk;
      repeat (brkLen - 10 * bitLen) @(posedge clk);
    end
    repeat (10 * bitLen + 10) @(posedge clk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // whole run needs some 10500 cycles
  initial begin
    #(20 * 60000);
    failures++;
    close_out;
  end

  initial begin
    int d, per, c, ctrl, n;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    w(2, 32'hFFFF);
    w(6, 32'hFFFF);
    for (int a = 0; a < 7; a++) rd(a, exp[a]);
    w(2, 0);
    done("registers");
    for (int m = 0; m < 4; m++) begin
      d = 3 + ($random(seed) & 7);
      per = m % 3 == 0 ? (d + 1) * 16 : m % 3 == 1 ? (d + 1) * 4 : d;
      ctrl = 32'h8000 | m << 9 | (m % 3 == 2 ? 32'h88 : (m % 3) << 3);
      w(0, 0);
      w(1, d);
      w(0, ctrl);
      repeat (3 * per + 10) @(posedge clk);
      `CHK(tickGap, per)
    end
    w(0, ctrl ^ 32'h688);
    rd(0, exp[0]);
    done("baud");
    for (int i = 0; i < 3; i++) begin
      w(4, 32'h37);
      pulse(7'h01 << i, 1);
      exp[4] |= 32'h100 << i;
      rd(4, exp[4]);
      `CHK(smartCardIrq, 1)
    end
    w(4, 32'h100);
    `CHK(smartCardIrq, 0)
    w(4, 32'h20);
    pulse(7'h60, 4);
    rd(4, exp[4]);
    pulse(7'h60, 1);
    exp[4] |= 32'h2000;
    rd(4, exp[4]);
    c = $random(seed) & 3;
    w(0, exp[0] & ~32'h30 | c << 4);
    w(4, 32'h10);
    pulse(7'h18, c + 1);
    rd(4, exp[4]);
    pulse(7'h18, 1);
    exp[4] |= 32'h1000;
    rd(4, exp[4]);
    `CHK(smartCardIrq, 1)
    done("card flags");
    w(0, 32'h9000);
    brk;
    exp[3] |= 4;
    sync;
    exp[5] |= 32'h80;
    rd(3, exp[3]);
    rd(5, exp[5]);
    `CHK(eventIrq, 1)
    w(5, 0);
    `CHK(eventIrq, 0)
    w(3, 0);
    done("wake");
    for (int m = 0; m < 3; m++) begin
      ctrl = 32'h8040 | (m == 1 ? 32'h8 : 0) | (m == 2 ? 32'h1080 : 0);
      n = 8 * bitLen + 4;
      d = m == 2 ? n >> 3 : (n >> (m ? 5 : 7)) - 1;
      w(0, 0);
      w(3, 0);
      w(5, m == 1 ? 0 : 4);
      if (m == 0) begin
        brk;
        exp[3] |= 4;
        rd(3, exp[3]);
      end
      brkLen = m == 2 ? 13 * bitLen : 0;
      w(0, ctrl);
      sync;
      exp[0] &= ~32'h40;
      exp[1] = d;
      exp[5] |= m == 2 ? 32'hC0 : 32'h40;
      for (int a = 0; a < 6; a++) rd(a, exp[a]);
      `CHK(eventIrq, m != 1)
    end
    done("auto-baud");
    close_out;
  end
endmodule // tb
